/* design/swd_watchdog.sv */
// SMBus register slave and watchdog countdown with level or pulse output.
// Assumes scl and sda inputs already synchronous to clk, and an external
// open-drain buffer that pulls sda low while sda_oe_n is low.
`timescale 1ns/1ps

module swd_watchdog #(
   parameter int CYCLES_PER_MS = swd_pkg::MS_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic addr_strap,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic timeout_output_pin,
   output logic timeout_output_sel,
   output logic alt_timeout_output_pin,
   output logic alt_timeout_output_sel,
   output logic irq_output_sel
);

   swd_pkg::swd_bus_state_t state;
   logic scl_q, sda_q, strap_taken, rw, fired, wd_asserted;
   logic [7:0] dev_addr, shift, index, pin_func, ctrl, range, count, rd_data, rx_byte;
   logic [2:0] bitcnt;
   logic [1:0] phase;
   logic [11:0] pulse_cnt, pw_ms;
   logic scl_rise, scl_fall, bus_start, bus_stop, byte_done, wr_stb;
   logic wr_ctrl, wr_range, reload, unit_tick, timeout_evt, en;
   logic ms_tick, sec_tick, min_tick;

   // ****************************************************************
   // Bus edge detection and decoded strobes
   // ****************************************************************
   assign scl_rise = scl_in && !scl_q;
   assign scl_fall = !scl_in && scl_q;
   assign bus_start = scl_in && scl_q && sda_q && !sda_in;
   assign bus_stop = scl_in && scl_q && !sda_q && sda_in;
   assign rx_byte = {shift[6:0], sda_in};
   assign byte_done = (state == swd_pkg::SWD_RX) && scl_rise && (bitcnt == swd_pkg::LAST_BIT) && !bus_start;
   assign wr_stb = byte_done && (phase == swd_pkg::PH_DATA);
   assign wr_ctrl = wr_stb && (index == swd_pkg::IDX_WD_CTRL);
   assign wr_range = wr_stb && (index == swd_pkg::IDX_WD_RANGE);
   assign en = ctrl[swd_pkg::CTRL_EN];

   // The strap is caught once, on the first clock after reset release.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         strap_taken <= 1'b0;
         dev_addr <= swd_pkg::ADDR_STRAP_INT;
      end else if (!strap_taken) begin
         strap_taken <= 1'b1;
         dev_addr <= addr_strap ? swd_pkg::ADDR_STRAP_INT : swd_pkg::ADDR_STRAP_EXT;
      end
   end

   // Read data for the currently selected index.
   always_comb begin
      case (index)
         swd_pkg::IDX_PIN_FUNC: rd_data = pin_func;
         swd_pkg::IDX_WD_CTRL: rd_data = ctrl;
         swd_pkg::IDX_WD_RANGE: rd_data = range;
         default: rd_data = swd_pkg::UNMAPPED_READ;
      endcase
   end

   // ****************************************************************
   // SMBus byte engine
   // ****************************************************************
   // Start and stop win over any state; the slave pulls sda only for its ack and read bits.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= swd_pkg::SWD_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         shift <= 8'h00;
         bitcnt <= 3'h0;
         phase <= swd_pkg::PH_ADDR;
         rw <= 1'b0;
         index <= 8'h00;
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         sda_out <= 1'b0;
         if (bus_start) begin
            state <= swd_pkg::SWD_RX;
            bitcnt <= 3'h0;
            phase <= swd_pkg::PH_ADDR;
            sda_oe_n <= 1'b1;
         end else if (bus_stop) begin
            state <= swd_pkg::SWD_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (state)
               swd_pkg::SWD_RX: begin
                  if (scl_rise) begin
                     shift <= rx_byte;
                     bitcnt <= bitcnt + 3'h1;
                     if (bitcnt == swd_pkg::LAST_BIT) begin
                        state <= swd_pkg::SWD_ACKW;
                        if (phase == swd_pkg::PH_ADDR) begin
                           rw <= sda_in;
                           if (rx_byte[7:1] != dev_addr[7:1]) begin
                              state <= swd_pkg::SWD_IDLE;
                           end
                        end else if (phase == swd_pkg::PH_CMD) begin
                           index <= rx_byte;
                        end
                     end
                  end
               end
               swd_pkg::SWD_ACKW: begin
                  if (scl_fall) begin
                     sda_oe_n <= 1'b0;
                     state <= swd_pkg::SWD_ACK;
                  end
               end
               swd_pkg::SWD_ACK: begin
                  if (scl_fall) begin
                     bitcnt <= 3'h0;
                     if (rw && phase == swd_pkg::PH_ADDR) begin
                        state <= swd_pkg::SWD_TX;
                        shift <= rd_data;
                        sda_oe_n <= rd_data[7];
                     end else begin
                        state <= swd_pkg::SWD_RX;
                        sda_oe_n <= 1'b1;
                        phase <= (phase == swd_pkg::PH_ADDR) ? swd_pkg::PH_CMD : swd_pkg::PH_DATA;
                     end
                  end
               end
               swd_pkg::SWD_TX: begin
                  if (scl_fall) begin
                     if (bitcnt == swd_pkg::LAST_BIT) begin
                        sda_oe_n <= 1'b1;
                        state <= swd_pkg::SWD_MACK;
                     end else begin
                        shift <= {shift[6:0], 1'b0};
                        sda_oe_n <= shift[6];
                        bitcnt <= bitcnt + 3'h1;
                     end
                  end
               end
               swd_pkg::SWD_MACK: begin
                  if (scl_rise && sda_in) begin
                     state <= swd_pkg::SWD_IDLE;
                  end else if (scl_fall) begin
                     state <= swd_pkg::SWD_TX;
                     bitcnt <= 3'h0;
                     shift <= rd_data;
                     sda_oe_n <= rd_data[7];
                  end
               end
               default: begin
                  sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Pin function select register.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_func <= swd_pkg::PIN_RESET;
      end else if (wr_stb && index == swd_pkg::IDX_PIN_FUNC) begin
         pin_func <= rx_byte;
      end
   end

   // Control register; a timeout in the clearing cycle keeps the flag set.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl <= swd_pkg::CTRL_RESET;
      end else begin
         ctrl[swd_pkg::CTRL_RSVD] <= 1'b0;
         if (wr_ctrl) begin
            ctrl[swd_pkg::CTRL_EN:0] <= rx_byte[swd_pkg::CTRL_EN:0];
            ctrl[swd_pkg::CTRL_FLAG] <= timeout_evt || (ctrl[swd_pkg::CTRL_FLAG] && !rx_byte[swd_pkg::CTRL_FLAG]);
         end else if (timeout_evt) begin
            ctrl[swd_pkg::CTRL_FLAG] <= 1'b1;
         end
      end
   end

   // Range register.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         range <= swd_pkg::RANGE_RESET;
      end else if (wr_range) begin
         range <= rx_byte;
      end
   end

   // ****************************************************************
   // Countdown
   // ****************************************************************
   assign reload = wr_range || (wr_ctrl && rx_byte[swd_pkg::CTRL_EN] && !en);
   assign unit_tick = ctrl[swd_pkg::CTRL_UNIT] ? min_tick : sec_tick;
   assign timeout_evt = en && !fired && unit_tick && !reload && (count <= 8'h01);

   swd_tick #(
      .CYCLES_PER_MS(CYCLES_PER_MS)
   ) u_tick (
      .clk(clk),
      .reset(reset),
      .restart(reload),
      .ms_tick(ms_tick),
      .sec_tick(sec_tick),
      .min_tick(min_tick)
   );

   // Count loads on reload and steps down once per unit while enabled and not yet fired.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= swd_pkg::RANGE_RESET;
         fired <= 1'b0;
      end else if (reload) begin
         count <= wr_range ? rx_byte : range;
         fired <= 1'b0;
      end else if (timeout_evt) begin
         count <= 8'h00;
         fired <= 1'b1;
      end else if (en && !fired && unit_tick) begin
         count <= count - 8'h01;
      end
   end

   // ****************************************************************
   // Watchdog output
   // ****************************************************************
   // Pulse width in milliseconds.
   always_comb begin
      case (ctrl[swd_pkg::CTRL_PW_HI:swd_pkg::CTRL_PW_LO])
         swd_pkg::PW_SEL_1MS: pw_ms = swd_pkg::PW_1MS;
         swd_pkg::PW_SEL_20MS: pw_ms = swd_pkg::PW_20MS;
         swd_pkg::PW_SEL_100MS: pw_ms = swd_pkg::PW_100MS;
         default: pw_ms = swd_pkg::PW_4S;
      endcase
   end

   // Asserted state: held in level form, timed in ms ticks in pulse form.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wd_asserted <= 1'b0;
         pulse_cnt <= 12'h000;
      end else if (!en) begin
         wd_asserted <= 1'b0;
         pulse_cnt <= 12'h000;
      end else if (timeout_evt) begin
         wd_asserted <= 1'b1;
         pulse_cnt <= pw_ms;
      end else if (reload) begin
         wd_asserted <= 1'b0;
      end else if (ctrl[swd_pkg::CTRL_PULSE] && wd_asserted && ms_tick) begin
         pulse_cnt <= pulse_cnt - 12'h001;
         if (pulse_cnt <= 12'h001) begin
            wd_asserted <= 1'b0;
         end
      end
   end

   // Pin drive with polarity and routing selects.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         timeout_output_pin <= 1'b1;
         alt_timeout_output_pin <= 1'b1;
         timeout_output_sel <= 1'b0;
         alt_timeout_output_sel <= 1'b0;
         irq_output_sel <= 1'b0;
      end else begin
         timeout_output_pin <= wd_asserted ~^ ctrl[swd_pkg::CTRL_POL];
         alt_timeout_output_pin <= wd_asserted ~^ ctrl[swd_pkg::CTRL_POL];
         timeout_output_sel <= pin_func[swd_pkg::PIN1_HI];
         alt_timeout_output_sel <= pin_func[swd_pkg::PIN2_HI:swd_pkg::PIN2_LO] == swd_pkg::FN_WD_ALT;
         irq_output_sel <= pin_func[swd_pkg::PIN2_HI:swd_pkg::PIN2_LO] == swd_pkg::FN_IRQ;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_addr_miss: assert property (@(posedge clk) disable iff (reset)
      (byte_done && phase == swd_pkg::PH_ADDR && rx_byte[7:1] != dev_addr[7:1]) |=> state == swd_pkg::SWD_IDLE)
      else $error("Foreign address was not ignored.");
   a_route_first: assert property (@(posedge clk) disable iff (reset)
      (wr_stb && index == swd_pkg::IDX_PIN_FUNC) |-> ##2 timeout_output_sel == $past(rx_byte[swd_pkg::PIN1_HI], 2))
      else $error("First pin routing does not follow its function field.");
   a_rsvd_zero: assert property (@(posedge clk) disable iff (reset)
      !ctrl[swd_pkg::CTRL_RSVD])
      else $error("Reserved control bit is not zero.");
   a_flag_set: assert property (@(posedge clk) disable iff (reset)
      timeout_evt |=> ctrl[swd_pkg::CTRL_FLAG] && wd_asserted)
      else $error("Timeout did not set the flag and output.");
   a_flag_clear: assert property (@(posedge clk) disable iff (reset)
      (wr_ctrl && rx_byte[swd_pkg::CTRL_FLAG] && !timeout_evt) |=> !ctrl[swd_pkg::CTRL_FLAG])
      else $error("Writing one did not clear the flag.");
   a_flag_keep: assert property (@(posedge clk) disable iff (reset)
      (wr_ctrl && !rx_byte[swd_pkg::CTRL_FLAG] && ctrl[swd_pkg::CTRL_FLAG]) |=> ctrl[swd_pkg::CTRL_FLAG])
      else $error("Writing zero changed the flag.");
   a_level_hold: assert property (@(posedge clk) disable iff (reset)
      (wd_asserted && en && !ctrl[swd_pkg::CTRL_PULSE] && !reload && !wr_ctrl) |=> wd_asserted)
      else $error("Level output dropped while enabled.");
   a_pulse_end: assert property (@(posedge clk) disable iff (reset)
      (wd_asserted && en && ctrl[swd_pkg::CTRL_PULSE] && ms_tick && pulse_cnt == 12'h001 && !wr_stb) |=> !wd_asserted)
      else $error("Pulse did not end on its last millisecond.");
   a_reload_count: assert property (@(posedge clk) disable iff (reset)
      wr_range |=> count == $past(rx_byte) && !fired)
      else $error("Range write did not reload the count.");
   a_stop_level: assert property (@(posedge clk) disable iff (reset)
      !en |=> !wd_asserted ##1 timeout_output_pin == !$past(ctrl[swd_pkg::CTRL_POL]))
      else $error("Disabled watchdog still asserts its output.");

endmodule

/* common/swd_pkg.sv */
// Shared constants for the watchdog block: register indexes, field positions,
// reset values, pin function codes, timing figures and the bus state type.
// Assumes a single 50 MHz clock and an SMBus host that drives byte transfers.
package swd_pkg;

   // ****************************************************************
   // Register indexes and slave addresses
   // ****************************************************************
   localparam logic [7:0] IDX_PIN_FUNC = 8'h03;
   localparam logic [7:0] IDX_WD_CTRL = 8'h36;
   localparam logic [7:0] IDX_WD_RANGE = 8'h37;
   localparam logic [7:0] ADDR_STRAP_INT = 8'h9C;
   localparam logic [7:0] ADDR_STRAP_EXT = 8'h6E;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int CTRL_RSVD = 7;
   localparam int CTRL_FLAG = 6;
   localparam int CTRL_EN = 5;
   localparam int CTRL_PULSE = 4;
   localparam int CTRL_UNIT = 3;
   localparam int CTRL_POL = 2;
   localparam int CTRL_PW_HI = 1;
   localparam int CTRL_PW_LO = 0;
   localparam int PIN1_HI = 1;
   localparam int PIN1_LO = 0;
   localparam int PIN2_HI = 4;
   localparam int PIN2_LO = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] RANGE_RESET = 8'h00;
   localparam logic [7:0] PIN_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ****************************************************************
   // Pin function codes and pulse width codes
   // ****************************************************************
   localparam logic [1:0] FN_WD_ALT = 2'h3;
   localparam logic [1:0] FN_IRQ = 2'h2;
   localparam logic [1:0] PW_SEL_1MS = 2'h0;
   localparam logic [1:0] PW_SEL_20MS = 2'h1;
   localparam logic [1:0] PW_SEL_100MS = 2'h2;

   // ****************************************************************
   // Timing figures
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0] MS_PER_SEC = 10'h3E8;
   localparam logic [5:0] SEC_PER_MIN = 6'h3C;
   localparam logic [11:0] PW_1MS = 12'h001;
   localparam logic [11:0] PW_20MS = 12'h014;
   localparam logic [11:0] PW_100MS = 12'h064;
   localparam logic [11:0] PW_4S = 12'hFA0;

   // ****************************************************************
   // Bus phases and states
   // ****************************************************************
   localparam logic [1:0] PH_ADDR = 2'h0;
   localparam logic [1:0] PH_CMD = 2'h1;
   localparam logic [1:0] PH_DATA = 2'h2;
   localparam logic [2:0] LAST_BIT = 3'h7;

   typedef enum logic [2:0] {
      SWD_IDLE = 3'b000,
      SWD_RX = 3'b001,
      SWD_ACKW = 3'b010,
      SWD_ACK = 3'b011,
      SWD_TX = 3'b100,
      SWD_MACK = 3'b101
   } swd_bus_state_t;

endpackage

/* design/swd_tick.sv */
// Time base for the watchdog: millisecond, second and minute strobes.
// Assumes the caller restarts it whenever the countdown is reloaded.
`timescale 1ns/1ps

module swd_tick #(
   parameter int CYCLES_PER_MS = swd_pkg::MS_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic restart,
   output logic ms_tick,
   output logic sec_tick,
   output logic min_tick
);

   logic [31:0] cyc;
   logic [9:0] ms_cnt;
   logic [5:0] sec_cnt;
   logic ms_end;
   logic sec_end;

   assign ms_end = (cyc == 32'(CYCLES_PER_MS - 1));
   assign sec_end = ms_end && (ms_cnt == swd_pkg::MS_PER_SEC - 10'h001);

   // Cascaded counters; restart lines up the first unit with the reload.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cyc <= 32'h0000_0000;
         ms_cnt <= 10'h000;
         sec_cnt <= 6'h00;
         ms_tick <= 1'b0;
         sec_tick <= 1'b0;
         min_tick <= 1'b0;
      end else if (restart) begin
         cyc <= 32'h0000_0000;
         ms_cnt <= 10'h000;
         sec_cnt <= 6'h00;
         ms_tick <= 1'b0;
         sec_tick <= 1'b0;
         min_tick <= 1'b0;
      end else begin
         cyc <= ms_end ? 32'h0000_0000 : cyc + 32'h0000_0001;
         ms_tick <= ms_end;
         sec_tick <= sec_end;
         min_tick <= sec_end && (sec_cnt == swd_pkg::SEC_PER_MIN - 6'h01);
         if (ms_end) begin
            ms_cnt <= sec_end ? 10'h000 : ms_cnt + 10'h001;
         end
         if (sec_end) begin
            sec_cnt <= (sec_cnt == swd_pkg::SEC_PER_MIN - 6'h01) ? 6'h00 : sec_cnt + 6'h01;
         end
      end
   end

endmodule

/* test/swd_host.sv */
// SMBus host model that reads and writes the watchdog registers a byte at a time.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps

module swd_host (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_drv
);
   // ****************************************************************
   // Bus cycles
   // ****************************************************************
   // The bus idles released, clock high.
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // Waits n cycles, then moves just after the edge.
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Data moves one cycle after scl falls, so no false start or stop is seen.
   task automatic bit_x(input logic b, output logic s);
      tk(1);
      sda_drv = b;
      tk(3);
      scl = 1'b1;
      tk(2);
      s = sda;
      tk(2);
      scl = 1'b0;
   endtask

   // Start, also used as repeated start with scl low.
   task automatic start();
      tk(1);
      sda_drv = 1'b1;
      tk(3);
      scl = 1'b1;
      tk(4);
      sda_drv = 1'b0;
      tk(4);
      scl = 1'b0;
   endtask

   // Stop ends the frame with the bus released.
   task automatic stop();
      tk(1);
      sda_drv = 1'b0;
      tk(3);
      scl = 1'b1;
      tk(4);
      sda_drv = 1'b1;
      tk(4);
   endtask

   // Eight bits MSB first, then the ninth bit released; ack is the slave pulling low.
   task automatic byte_x(input logic [7:0] b, output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], r[i]);
      end
      bit_x(1'b1, s);
      ack = ~s;
   endtask

   // Address, index and data byte, acked all through.
   task automatic write_reg(input logic [7:0] adr, input logic [7:0] idx, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic a1, a2, a3;
      start();
      byte_x(adr, r, a1);
      byte_x(idx, r, a2);
      byte_x(d, r, a3);
      stop();
      ok = a1 & a2 & a3;
   endtask

   // Index set by a write frame, then repeated start and one byte read with a nack.
   task automatic read_reg(input logic [7:0] adr, input logic [7:0] idx, output logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic a1, a2, a3, n;
      start();
      byte_x(adr, r, a1);
      byte_x(idx, r, a2);
      start();
      byte_x(adr | 8'h01, r, a3);
      byte_x(8'hFF, d, n);
      stop();
      ok = a1 & a2 & a3;
   endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the watchdog: register access over SMBus and pin timing.
// Assumes the host model drives the bus and the time base is shortened.
`timescale 1ns/1ps

module tb;
   // ****************************************************************
   // Bench signals and instances
   // ****************************************************************
   localparam int CPM = 5;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic addr_strap = 1'b1;
   logic scl, sda_drv, sda_out, sda_oe_n, wd_pin, wd_sel, alt_pin, alt_sel, irq_sel, ak;
   logic [7:0] dev = swd_pkg::ADDR_STRAP_INT;
   int checks = 0;
   int fail_count = 0;
   int n;
   int ms[4] = '{1, 20, 100, 4000};
   wire sda = sda_drv & (sda_oe_n | sda_out); // Wired-and bus with pull-up; the slave pulls low while sda_oe_n is low.

   // Clock of 20 ns period.
   always #10 clk = ~clk;

   swd_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

   swd_watchdog #(.CYCLES_PER_MS(CPM)) i_dut (.clk(clk), .reset(reset), .addr_strap(addr_strap),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .timeout_output_pin(wd_pin),
      .timeout_output_sel(wd_sel), .alt_timeout_output_pin(alt_pin), .alt_timeout_output_sel(alt_sel),
      .irq_output_sel(irq_sel));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic tk(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      i_host.write_reg(dev, idx, d, ak);
      check("write ack", ak, 1);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      i_host.read_reg(dev, idx, d, ak);
      check(what, {ak, d}, {1'b1, exp});
   endtask

   // Bounded wait for the watchdog pin; running out ends the run.
   task automatic wait_pin(input logic v, input int lim);
      n = 0;
      while (wd_pin !== v && n < lim) begin
         tk(1);
         n++;
      end
      if (n >= lim) begin
         check("pin wait", 0, 1);
         test_done();
      end
   endtask

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      tk(16);
      reset = 1'b0;
      tk(4);
      rd_chk("ctrl reset", swd_pkg::IDX_WD_CTRL, 8'h00);
      rd_chk("range reset", swd_pkg::IDX_WD_RANGE, 8'h00);
      check("pin idle", wd_pin, 1);
      check("sda out", sda_out, 0);
      rd_chk("unmapped", 8'h10, 8'h00);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         wr(swd_pkg::IDX_PIN_FUNC, 8'(c * 9));
         check("first sel", wd_sel, c >= 2);
         check("second sel", alt_sel, c == 3);
         check("irq sel", irq_sel, c == 2);
         rd_chk("pin func", swd_pkg::IDX_PIN_FUNC, 8'(c * 9));
      end
      wr(swd_pkg::IDX_WD_CTRL, 8'h80);
      rd_chk("reserved", swd_pkg::IDX_WD_CTRL, 8'h00);
      $display("test pins done");
      // Level mode, low active; a range rewrite must restart the count.
      wr(swd_pkg::IDX_WD_RANGE, 8'h02);
      wr(swd_pkg::IDX_WD_CTRL, 8'h20);
      tk(7500);
      check("early", wd_pin, 1);
      wr(swd_pkg::IDX_WD_RANGE, 8'h02);
      tk(7500);
      check("reloaded", wd_pin, 1);
      wait_pin(1'b0, 3000);
      check("alt pin", alt_pin, 0);
      rd_chk("flag set", swd_pkg::IDX_WD_CTRL, 8'h60);
      wr(swd_pkg::IDX_WD_CTRL, 8'h20);
      rd_chk("write zero", swd_pkg::IDX_WD_CTRL, 8'h60);
      wr(swd_pkg::IDX_WD_CTRL, 8'h60);
      rd_chk("write one", swd_pkg::IDX_WD_CTRL, 8'h20);
      check("level stands", wd_pin, 0);
      wr(swd_pkg::IDX_WD_CTRL, 8'h00);
      check("disabled", wd_pin, 1);
      $display("test level done");
      // Minute steps: one step must not expire within a second and a bit.
      wr(swd_pkg::IDX_WD_RANGE, 8'h01);
      wr(swd_pkg::IDX_WD_CTRL, 8'h28);
      tk(6000);
      check("minute", wd_pin, 1);
      rd_chk("no flag", swd_pkg::IDX_WD_CTRL, 8'h28);
      wr(swd_pkg::IDX_WD_CTRL, 8'h00);
      $display("test unit done");
      // Pulse mode, high active, every width code.
      for (int w = 0; w < 4; w++) begin
         wr(swd_pkg::IDX_WD_RANGE, 8'h00);
         wr(swd_pkg::IDX_WD_CTRL, 8'h34 | 8'(w));
         check("idle low", wd_pin, 0);
         wait_pin(1'b1, 7000);
         n = 0;
         while (wd_pin === 1'b1 && n < 25000) begin
            tk(1);
            n++;
         end
         check("width", n >= (ms[w] - 1) * CPM && n <= ms[w] * CPM + 2, 1);
         rd_chk("pulse flag", swd_pkg::IDX_WD_CTRL, 8'h74 | 8'(w));
         wr(swd_pkg::IDX_WD_CTRL, 8'h40);
      end
      $display("test pulse done");
      i_host.write_reg(8'h50, swd_pkg::IDX_WD_CTRL, 8'h20, ak);
      check("foreign addr", ak, 0);
      reset = 1'b1;
      addr_strap = 1'b0;
      tk(2);
      reset = 1'b0;
      tk(4);
      dev = swd_pkg::ADDR_STRAP_EXT;
      wr(swd_pkg::IDX_WD_RANGE, 8'h5A);
      rd_chk("ext strap", swd_pkg::IDX_WD_RANGE, 8'h5A);
      i_host.write_reg(swd_pkg::ADDR_STRAP_INT, swd_pkg::IDX_WD_RANGE, 8'h11, ak);
      check("int addr off", ak, 0);
      $display("test address done");
      test_done();
   end
endmodule
